// file: rtl/t1ja_consts.svh
/*
 * Constants of the T1 jitter attenuator and build-out control: clock rates,
 * divider moduli, depths, jitter limits, bit positions and reset values.
 * Assumes it is included by bare name, ahead of the package and modules.
 */
`ifndef T1JA_CONSTS_SVH
`define T1JA_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------------------
`define T1JA_MCLK_HZ            64'd1544000
`define T1JA_PLL_MULT           64'd16
`define T1JA_SYS_CLK_HZ         64'd200000000
`define T1JA_PHASE_BITS         32

// ----------------------------------------------------------------------------
// Read clock divider moduli
// ----------------------------------------------------------------------------
`define T1JA_DIV_NOMINAL        5'h10
`define T1JA_DIV_FAST           5'h0f
`define T1JA_DIV_SLOW           5'h11

// ----------------------------------------------------------------------------
// FIFO depths and jitter limits in UI peak to peak
// ----------------------------------------------------------------------------
`define T1JA_DEPTH_DEEP         128
`define T1JA_DEPTH_SHALLOW      32
`define T1JA_LIMIT_UIPP_DEEP    120
`define T1JA_LIMIT_UIPP_SHALLOW 28

// ----------------------------------------------------------------------------
// Bit positions and reset values
// ----------------------------------------------------------------------------
`define T1JA_RECEIVE_INFO_REG_THREE_TRIP_BIT      5
`define T1JA_RECEIVE_INFO_REG_THREE_RESET         8'h00

`endif

// file: rtl/t1ja_pkg.sv
/*
 * Types of the T1 jitter attenuator and build-out control.
 * Assumes the constants header is compiled alongside.
 */
package t1ja_pkg;

    // ------------------------------------------------------------------------
    // Line interface control byte, MSB first
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic build_out_sel_msb;
        logic build_out_sel_mid;
        logic build_out_sel_lsb;
        logic rx_gain_limit;
        logic atten_side_select;   // 0 receive path, 1 transmit path
        logic atten_depth_select;  // 0 deep, 1 shallow
        logic atten_disable;       // 1 bypass
        logic tx_power_down;
    } t1ja_line_interface_control_t;

    // One bit of a stream: clock strobe and the data it carries
    typedef struct packed {
        logic en;
        logic data;
    } t1ja_bit_t;

    typedef enum logic [2:0] {
        T1JA_LBO_DSX_0_133,
        T1JA_LBO_DSX_133_266,
        T1JA_LBO_DSX_266_399,
        T1JA_LBO_DSX_399_533,
        T1JA_LBO_DSX_533_655,
        T1JA_LBO_CSU_7P5DB,
        T1JA_LBO_CSU_15DB,
        T1JA_LBO_CSU_22P5DB
    } t1ja_lbo_t;

endpackage

// file: rtl/t1ja_rate_div.sv
/*
 * Read clock divider of the jitter attenuator: counts high-rate ticks and
 * emits one read strobe per period of 16, or 15 or 17 under protection.
 * Assumes the high-rate tick is a one-cycle enable on i_mclk.
 */
`timescale 1ns/1ps
`include "t1ja_consts.svh"

module t1ja_rate_div (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_hr_en,
    input  wire logic i_speed_up,
    input  wire logic i_slow_down,
    output logic      o_rd_en,
    output logic      o_clk_level,
    output logic      o_trip
);

    typedef struct packed {
        logic [4:0] count;
        logic [4:0] modulus;
        logic       level;
        logic       trip;
    } t1ja_div_state_t;

    t1ja_div_state_t s_r;
    t1ja_div_state_t s_nxt;
    logic            wrap;

    assign wrap = i_hr_en && (s_r.count == 5'(s_r.modulus - 5'h01));

    always_comb
    begin
        s_nxt = s_r;
        if (i_hr_en)
        begin
            if (wrap)
            begin
                s_nxt.count = 5'h00;
                // Modulus is chosen per period, so a change never cuts a period short
                if (i_speed_up)
                    s_nxt.modulus = `T1JA_DIV_FAST;
                else if (i_slow_down)
                    s_nxt.modulus = `T1JA_DIV_SLOW;
                else
                    s_nxt.modulus = `T1JA_DIV_NOMINAL;
            end
            else
                s_nxt.count = 5'(s_r.count + 5'h01);
        end
        // High for the first half of each period gives a near square clock
        s_nxt.level = (s_nxt.count < 5'(s_nxt.modulus >> 1));
        s_nxt.trip  = (s_nxt.modulus != `T1JA_DIV_NOMINAL);
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            s_r <= '{count: 5'h00, modulus: `T1JA_DIV_NOMINAL, level: 1'b1, trip: 1'b0};
        else
            s_r <= s_nxt;
    end

    assign o_rd_en     = wrap;
    assign o_clk_level = s_r.level;
    assign o_trip      = s_r.trip;

endmodule // t1ja_rate_div

// file: rtl/t1ja_top.sv
/*
 * Jitter attenuator and transmit build-out control of a T1 line interface.
 * Holds the attenuator FIFO, path selection and bypass, the high-rate tick
 * generator and the build-out decode.
 * Assumes all inputs are synchronous to i_mclk and that line clocks arrive
 * as one-cycle strobes, one per bit.
 */
`timescale 1ns/1ps
`include "t1ja_consts.svh"

module t1ja_top #(
    parameter int DEPTH_DEEP    = `T1JA_DEPTH_DEEP,
    parameter int DEPTH_SHALLOW = `T1JA_DEPTH_SHALLOW,
    parameter int LIMIT_DEEP    = `T1JA_LIMIT_UIPP_DEEP,
    parameter int LIMIT_SHALLOW = `T1JA_LIMIT_UIPP_SHALLOW
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst_b,
    input  t1ja_pkg::t1ja_line_interface_control_t    i_line_interface_control,
    input  t1ja_pkg::t1ja_bit_t     i_rx_line,
    input  t1ja_pkg::t1ja_bit_t     i_tx_clock_input,
    output t1ja_pkg::t1ja_bit_t     o_rx_framer,
    output t1ja_pkg::t1ja_bit_t     o_tx_line,
    output logic                    o_rx_clk_level,
    output t1ja_pkg::t1ja_lbo_t     o_lbo_shape,
    output logic                    o_lbo_csu,
    output logic                    o_atten_limit_trip_flag,
    output logic [7:0]              o_receive_info_reg_three
);

    // ------------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------------
    localparam int PW = $clog2(DEPTH_DEEP);
    localparam int PB = `T1JA_PHASE_BITS;
    localparam logic [PB-1:0] PHASE_INC =
        PB'(((`T1JA_MCLK_HZ * `T1JA_PLL_MULT) << PB) / `T1JA_SYS_CLK_HZ);

    // Refused at elaboration: pointer wrap masks need powers of two
    if ((DEPTH_DEEP & (DEPTH_DEEP - 1)) != 0 || (DEPTH_SHALLOW & (DEPTH_SHALLOW - 1)) != 0)
    begin : g_bad_pow2
        $error("t1ja_top: depths must be powers of two");
    end
    if (DEPTH_SHALLOW < 4 || DEPTH_SHALLOW > DEPTH_DEEP)
    begin : g_bad_shallow
        $error("t1ja_top: shallow depth must lie between 4 and the deep depth");
    end
    if (LIMIT_DEEP >= DEPTH_DEEP || LIMIT_SHALLOW >= DEPTH_SHALLOW)
    begin : g_bad_limit
        $error("t1ja_top: jitter limits must be below their depths");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [PB-1:0]         phase;
        logic                  hr_en;
        logic [DEPTH_DEEP-1:0] mem;
        logic [PW-1:0]         wr_ptr;
        logic [PW-1:0]         rd_ptr;
        logic [PW:0]           fill;
        logic [2:0]            cfg;
        t1ja_pkg::t1ja_bit_t   rx_out;
        t1ja_pkg::t1ja_bit_t   tx_out;
        t1ja_pkg::t1ja_lbo_t   lbo;
        logic                  csu;
        logic                  trip;
    } t1ja_state_t;

    t1ja_state_t         s_r;
    t1ja_state_t         s_nxt;
    logic                rd_en;
    logic                clk_level;
    logic                div_trip;
    logic                speed_up;
    logic                slow_down;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [PW:0] depth_of(input logic shallow);
        depth_of = shallow ? (PW+1)'(DEPTH_SHALLOW) : (PW+1)'(DEPTH_DEEP);
    endfunction

    function automatic logic [PW-1:0] wrap_ptr(input logic [PW-1:0] ptr, input logic shallow);
        wrap_ptr = ptr & PW'(depth_of(shallow) - (PW+1)'(1));
    endfunction

    function automatic t1ja_pkg::t1ja_lbo_t lbo_decode(input t1ja_pkg::t1ja_line_interface_control_t c);
        lbo_decode = t1ja_pkg::t1ja_lbo_t'({c.build_out_sel_msb, c.build_out_sel_mid,
                                             c.build_out_sel_lsb});
    endfunction

    // ------------------------------------------------------------------------
    // Jitter limits: half the peak to peak excursion either side of centre
    // ------------------------------------------------------------------------
    logic [PW:0] centre;
    logic [PW:0] half_lim;

    always_comb
    begin
        centre    = depth_of(i_line_interface_control.atten_depth_select) >> 1;
        half_lim  = i_line_interface_control.atten_depth_select ?
                    (PW+1)'(LIMIT_SHALLOW / 2) : (PW+1)'(LIMIT_DEEP / 2);
        // Fill far above centre means writes outrun reads, so read faster
        speed_up  = (s_r.fill > (PW+1)'(centre + half_lim));
        slow_down = (s_r.fill < (PW+1)'(centre - half_lim));
    end

    t1ja_rate_div u_rate_div (
        .i_mclk      (i_mclk),
        .i_rst_b     (i_rst_b),
        .i_hr_en     (s_r.hr_en),
        .i_speed_up  (speed_up),
        .i_slow_down (slow_down),
        .o_rd_en     (rd_en),
        .o_clk_level (clk_level),
        .o_trip      (div_trip)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        t1ja_pkg::t1ja_bit_t wr_src;
        t1ja_pkg::t1ja_bit_t rd_bit;
        logic                carry;
        logic                shallow;
        logic                do_wr;
        logic                do_rd;
        logic [PW:0]         depth;

        s_nxt   = s_r;
        carry   = 1'b0;
        do_wr   = 1'b0;
        do_rd   = 1'b0;
        wr_src  = '0;
        rd_bit  = '0;
        shallow = i_line_interface_control.atten_depth_select;
        depth   = depth_of(shallow);

        // Fractional accumulator stands in for the x16 PLL; its accuracy
        // is only as good as the master clock it is referred to
        {carry, s_nxt.phase} = {1'b0, s_r.phase} + {1'b0, PHASE_INC};
        s_nxt.hr_en = carry;

        // Write side follows the chosen path; strobes may be gapped
        wr_src = i_line_interface_control.atten_side_select ? i_tx_clock_input : i_rx_line;
        do_wr  = wr_src.en && (s_r.fill < depth);
        do_rd  = rd_en && (s_r.fill != '0);

        if (do_wr)
        begin
            s_nxt.mem[s_r.wr_ptr] = wr_src.data;
            s_nxt.wr_ptr          = wrap_ptr(PW'(s_r.wr_ptr + PW'(1)), shallow);
        end

        // Smoothed read strobe keeps running when empty, repeating the stale bit at the stalled read pointer
        rd_bit.en   = rd_en;
        rd_bit.data = s_r.mem[s_r.rd_ptr];
        if (do_rd)
            s_nxt.rd_ptr = wrap_ptr(PW'(s_r.rd_ptr + PW'(1)), shallow);

        s_nxt.fill = (PW+1)'(s_r.fill + (PW+1)'(do_wr) - (PW+1)'(do_rd));

        // Setting change: drop the excursion history and start half full
        s_nxt.cfg = {i_line_interface_control.atten_side_select, shallow,
                     i_line_interface_control.atten_disable};
        if (s_nxt.cfg != s_r.cfg)
        begin
            s_nxt.fill   = depth >> 1;
            s_nxt.rd_ptr = wrap_ptr(PW'(s_nxt.wr_ptr - PW'(depth >> 1)), shallow);
            s_nxt.wr_ptr = wrap_ptr(s_nxt.wr_ptr, shallow);
        end

        // Path routing
        if (i_line_interface_control.atten_disable)
        begin
            s_nxt.rx_out = i_rx_line;
            s_nxt.tx_out = i_tx_clock_input;
        end
        else if (i_line_interface_control.atten_side_select)
        begin
            s_nxt.rx_out = i_rx_line;
            s_nxt.tx_out = rd_bit;
        end
        else
        begin
            s_nxt.rx_out = rd_bit;
            s_nxt.tx_out = i_tx_clock_input;
        end

        // Shape is chosen from the select bits alone; the line side only
        // sees clock strobes, so clock duty cycle never reaches the shaper
        s_nxt.lbo  = lbo_decode(i_line_interface_control);
        s_nxt.csu  = (s_nxt.lbo == t1ja_pkg::T1JA_LBO_CSU_7P5DB) ||
                     (s_nxt.lbo == t1ja_pkg::T1JA_LBO_CSU_15DB)  ||
                     (s_nxt.lbo == t1ja_pkg::T1JA_LBO_CSU_22P5DB);
        s_nxt.trip = div_trip && !i_line_interface_control.atten_disable;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            s_r        <= '0;
            s_r.fill   <= (PW+1)'(DEPTH_DEEP / 2);
            s_r.rd_ptr <= PW'(DEPTH_DEEP / 2);
            s_r.lbo    <= t1ja_pkg::T1JA_LBO_DSX_0_133;
        end
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always_comb
    begin
        o_receive_info_reg_three = `T1JA_RECEIVE_INFO_REG_THREE_RESET;
        o_receive_info_reg_three[`T1JA_RECEIVE_INFO_REG_THREE_TRIP_BIT] = s_r.trip;
    end

    assign o_rx_framer             = s_r.rx_out;
    assign o_tx_line               = s_r.tx_out;
    assign o_rx_clk_level          = clk_level;
    assign o_lbo_shape             = s_r.lbo;
    assign o_lbo_csu               = s_r.csu;
    assign o_atten_limit_trip_flag = s_r.trip;

endmodule // t1ja_top

// file: verification/t1ja_line_model.sv
/* Line side model: sends a run of bit strobes to the receive or transmit input.
   Assumes the bench clock; the unused input sees toggling data, no strobe. */
`timescale 1ns/1ps
module t1ja_line_model (
    input  wire logic           i_mclk,
    input  wire logic           i_rst_b,
    input  wire logic           i_go,
    input  wire logic           i_sel,
    input  wire logic [7:0]     i_period,
    input  wire logic [5:0]     i_count,
    input  wire logic [31:0]    i_pattern,
    output t1ja_pkg::t1ja_bit_t o_rx_bit,
    output t1ja_pkg::t1ja_bit_t o_tx_bit,
    output logic                o_busy
);
    t1ja_pkg::t1ja_bit_t bit_r;
    logic [7:0]          wait_r;
    logic [5:0]          left_r;
    logic [4:0]          idx_r;
    assign o_rx_bit = i_sel ? t1ja_pkg::t1ja_bit_t'({1'b0, bit_r.data}) : bit_r;
    assign o_tx_bit = i_sel ? bit_r : t1ja_pkg::t1ja_bit_t'({1'b0, bit_r.data});
    assign o_busy   = i_go || left_r != 6'h00;
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bit_r  <= '0;
            wait_r <= 8'h00;
            left_r <= 6'h00;
            idx_r  <= 5'h00;
        end
        else
        begin
            // Data between strobes changes every cycle, so nothing can lean on a held value
            bit_r <= t1ja_pkg::t1ja_bit_t'({1'b0, ~bit_r.data});
            if (i_go)
            begin
                left_r <= i_count;
                idx_r  <= 5'h00;
                wait_r <= 8'h00;
            end
            else if (left_r != 6'h00 && wait_r == 8'h00)
            begin
                bit_r  <= t1ja_pkg::t1ja_bit_t'({1'b1, i_pattern[idx_r]});
                idx_r  <= idx_r + 5'h01;
                left_r <= left_r - 6'h01;
                wait_r <= i_period - 8'h01;
            end
            else if (left_r != 6'h00)
                wait_r <= wait_r - 8'h01;
        end
    end
endmodule // t1ja_line_model

// file: verification/t1ja_monitor.sv
/* Checker of the T1 jitter attenuator top, bound to t1ja_top.
   Assumes one clock domain, i_mclk at 200 MHz and the default depths. */
`timescale 1ns/1ps
module t1ja_monitor (
    input  wire logic            i_mclk,
    input  wire logic            i_rst_b,
    input  t1ja_pkg::t1ja_line_interface_control_t i_line_interface_control,
    input  t1ja_pkg::t1ja_bit_t  i_rx_line,
    input  t1ja_pkg::t1ja_bit_t  i_tx_clock_input,
    input  t1ja_pkg::t1ja_bit_t  o_rx_framer,
    input  t1ja_pkg::t1ja_bit_t  o_tx_line,
    input  t1ja_pkg::t1ja_lbo_t  o_lbo_shape,
    input  logic                 o_lbo_csu,
    input  logic                 o_atten_limit_trip_flag,
    input  logic [7:0]           o_receive_info_reg_three
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    logic [2:0] cfg;
    logic [2:0] cfg_r;
    logic       rx_att;
    logic       tx_att;
    logic [7:0] gap_r;
    assign cfg    = {i_line_interface_control.atten_side_select, i_line_interface_control.atten_depth_select,
                     i_line_interface_control.atten_disable};
    assign rx_att = !cfg[0] && !cfg[2];
    assign tx_att = !cfg[0] && cfg[2];
    // Cycles since the last attenuated receive strobe; any setting change disarms it
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cfg_r <= 3'h0;
            gap_r <= 8'h00;
        end
        else
        begin
            cfg_r <= cfg;
            if (!rx_att || cfg != cfg_r)
                gap_r <= 8'h00;
            else if (o_rx_framer.en)
                gap_r <= 8'h01;
            else if (gap_r != 8'h00 && gap_r != 8'hff)
                gap_r <= gap_r + 8'h01;
        end
    end
    property p_lbo_shape;
        1'b1 |=> o_lbo_shape == $past(i_line_interface_control[7:5]);
    endproperty
    a_lbo_shape: assert property (p_lbo_shape) else $error("build-out shape wrong");
    property p_lbo_csu;
        1'b1 |=> o_lbo_csu == $past(i_line_interface_control[7] && i_line_interface_control[6:5] != 2'h0);
    endproperty
    a_lbo_csu: assert property (p_lbo_csu) else $error("csu flag wrong");
    property p_rx_thru;
        !rx_att [*2] |=> o_rx_framer.en == $past(i_rx_line.en)
            && (!o_rx_framer.en || o_rx_framer.data == $past(i_rx_line.data));
    endproperty
    a_rx_thru: assert property (p_rx_thru) else $error("receive pass-through wrong");
    property p_tx_thru;
        !tx_att [*2] |=> o_tx_line.en == $past(i_tx_clock_input.en)
            && (!o_tx_line.en || o_tx_line.data == $past(i_tx_clock_input.data));
    endproperty
    a_tx_thru: assert property (p_tx_thru) else $error("transmit pass-through wrong");
    property p_reg3;
        1'b1 |-> o_receive_info_reg_three == {2'h0, o_atten_limit_trip_flag, 5'h00};
    endproperty
    a_reg3: assert property (p_reg3) else $error("info register bits wrong");
    property p_trip_off;
        i_line_interface_control.atten_disable [*2] |-> !o_atten_limit_trip_flag;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("trip flag while bypassed");
    property p_gap_min;
        rx_att && cfg == cfg_r && o_rx_framer.en && gap_r != 8'h00 |-> gap_r >= 8'h79;
    endproperty
    a_gap_min: assert property (p_gap_min) else $error("read strobes too close");
    property p_gap_max;
        gap_r != 8'h00 |-> gap_r <= 8'h8a;
    endproperty
    a_gap_max: assert property (p_gap_max) else $error("read strobe late");
endmodule // t1ja_monitor

bind t1ja_top t1ja_monitor t1ja_monitor_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_line_interface_control(i_line_interface_control),
    .i_rx_line(i_rx_line), .i_tx_clock_input(i_tx_clock_input), .o_rx_framer(o_rx_framer),
    .o_tx_line(o_tx_line), .o_lbo_shape(o_lbo_shape), .o_lbo_csu(o_lbo_csu),
    .o_atten_limit_trip_flag(o_atten_limit_trip_flag), .o_receive_info_reg_three(o_receive_info_reg_three)
);

// file: verification/t1ja_top_tb.sv
/* Self-checking bench of the T1 jitter attenuator top.
   Assumes a 200 MHz i_mclk and the line model on both stream inputs. */
`timescale 1ns/1ps
module t1ja_top_tb;
    logic                 i_mclk, i_rst_b, go, sel, busy, csu, trip, clk_lvl;
    t1ja_pkg::t1ja_line_interface_control_t line_interface_control;
    t1ja_pkg::t1ja_bit_t  rx_in, tx_in, rx_out, tx_out;
    t1ja_pkg::t1ja_lbo_t  lbo;
    logic [7:0]           receive_info_reg_three, period;
    logic [5:0]           count;
    logic [31:0]          pattern;
    int                   num_errors, num_checks, cyc, off;
    int                   rx_t[$], tx_t[$];
    logic                 rx_d[$], tx_d[$];
    t1ja_top t1ja_top_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_line_interface_control(line_interface_control),
        .i_rx_line(rx_in), .i_tx_clock_input(tx_in), .o_rx_framer(rx_out), .o_tx_line(tx_out),
        .o_rx_clk_level(clk_lvl), .o_lbo_shape(lbo), .o_lbo_csu(csu), .o_atten_limit_trip_flag(trip),
        .o_receive_info_reg_three(receive_info_reg_three));
    t1ja_line_model t1ja_line_model_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_go(go), .i_sel(sel),
        .i_period(period), .i_count(count), .i_pattern(pattern), .o_rx_bit(rx_in), .o_tx_bit(tx_in),
        .o_busy(busy));
    // Ideal reference, no ppm offset
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk)
    begin
        cyc++;
        if (rx_out.en === 1'b1) begin rx_t.push_back(cyc); rx_d.push_back(rx_out.data); end
        if (tx_out.en === 1'b1) begin tx_t.push_back(cyc); tx_d.push_back(tx_out.data); end
    end
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin num_errors++; $display("BAD %0t got %h want %h", $time, got, exp); end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin num_errors++; $display("BAD %0t gap %0d", $time, got); end
    endtask
    task automatic clear;
        rx_t.delete(); rx_d.delete(); tx_t.delete(); tx_d.delete();
    endtask
    task automatic set_cfg(input logic [2:0] lb, input logic side, input logic dep, input logic dis);
        @(posedge i_mclk);
        line_interface_control <= {lb, 1'b0, side, dep, dis, 1'b0};
        repeat (3) @(posedge i_mclk);
        #1 clear();
    endtask
    task automatic send(input logic s, input logic [7:0] p, input logic [5:0] n, input logic [31:0] pat);
        int k = 0;
        @(posedge i_mclk);
        sel <= s; period <= p; count <= n; pattern <= pat; go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        #1;
        while (busy !== 1'b0 && k < 9000) begin @(posedge i_mclk); k++; end
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_n(input logic s, input int n, input int lim);
        for (int k = 0; k < lim && (s ? tx_t.size() : rx_t.size()) < n; k++) @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_flag(input logic v, input int lim);
        for (int k = 0; k < lim && trip !== v; k++) @(posedge i_mclk);
        #1 chk(8'(trip), 8'(v));
    endtask
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_lbo;
        for (int c = 0; c < 8; c++)
        begin
            set_cfg(3'(c), 1'b0, 1'b0, 1'b1);
            chk(8'(lbo), 8'(c));
            chk(8'(csu), 8'(c >= 5));
        end
        $display("build-out test done");
    endtask
    task automatic t_bypass;
        set_cfg(3'h0, 1'b0, 1'b0, 1'b1);
        send(1'b0, 8'h01, 6'h08, 32'h0000_00b4);
        send(1'b1, 8'h02, 6'h08, 32'h0000_005a);
        chk(8'(rx_t.size()), 8'h08);
        chk(8'(tx_t.size()), 8'h08);
        for (int i = 0; i < 8 && i < rx_t.size() && i < tx_t.size(); i++)
        begin
            chk(8'(rx_d[i]), 8'(8'hb4 >> i) & 8'h01);
            chk(8'(rx_t[i] - rx_t[0]), 8'(i));
            chk(8'(tx_d[i]), 8'(8'h5a >> i) & 8'h01);
            chk(8'(tx_t[i] - tx_t[0]), 8'(2 * i));
        end
        chk(8'(trip), 8'h00);
        $display("bypass test done");
    endtask
    task automatic t_side;
        int hi;
        set_cfg(3'h0, 1'b0, 1'b0, 1'b0);
        send(1'b1, 8'h03, 6'h04, 32'h0000_0009);
        chk(8'(tx_t.size()), 8'h04);
        for (int i = 0; i < 4 && i < tx_d.size(); i++) chk(8'(tx_d[i]), 8'(4'h9 >> i) & 8'h01);
        wait_n(1'b0, 4, 800);
        for (int i = 1; i < 4 && i < rx_t.size(); i++) chk_rng(rx_t[i] - rx_t[i - 1], 129, 130);
        // High for 8 of 16 ticks, so a 130-cycle window holds about 65 high cycles
        hi = 0;
        for (int k = 0; k < 130; k++)
        begin
            @(posedge i_mclk);
            hi += int'(clk_lvl === 1'b1);
        end
        chk_rng(hi, 63, 67);
        set_cfg(3'h0, 1'b1, 1'b0, 1'b0);
        send(1'b0, 8'h03, 6'h04, 32'h0000_0006);
        chk(8'(rx_t.size()), 8'h04);
        wait_n(1'b1, 3, 500);
        chk(8'(tx_t.size() >= 3), 8'h01);
        if (tx_t.size() >= 3) chk_rng(tx_t[2] - tx_t[1], 129, 130);
        $display("side select test done");
    endtask
    task automatic t_gapped;
        set_cfg(3'h0, 1'b1, 1'b1, 1'b0);
        send(1'b1, 8'h01, 6'h04, 32'h0000_000d);
        repeat (200) @(posedge i_mclk);
        send(1'b1, 8'h01, 6'h04, 32'h0000_000b);
        // Two bursts of four keep the fill well inside the shallow limits
        chk(8'(trip), 8'h00);
        wait_n(1'b1, 24, 4000);
        chk(8'(tx_t.size() >= 24), 8'h01);
        // Half-depth centre puts 16 old bits first; a read inside the settling cycles makes it 15
        off = (tx_d.size() > 23 && tx_d[16] === 1'b1 && tx_d[17] === 1'b0) ? 16 : 15;
        for (int i = 0; i < 8 && off + i < tx_d.size(); i++)
            chk(8'(tx_d[off + i]), 8'(8'hbd >> i) & 8'h01);
        // Twenty-four reads drain the FIFO below its lower limit, so the divider now runs slow
        chk(8'(trip), 8'h01);
        $display("gapped clock test done");
    endtask
    task automatic t_trip;
        set_cfg(3'h0, 1'b0, 1'b1, 1'b0);
        send(1'b0, 8'h01, 6'h14, 32'h0000_0000);
        wait_flag(1'b1, 400);
        chk(receive_info_reg_three, 8'h20);
        send(1'b0, 8'h01, 6'h14, 32'h0000_0000);
        clear();
        wait_n(1'b0, 2, 400);
        if (rx_t.size() >= 2) chk_rng(rx_t[1] - rx_t[0], 121, 122);
        wait_flag(1'b0, 1200);
        set_cfg(3'h0, 1'b0, 1'b1, 1'b1);
        set_cfg(3'h0, 1'b0, 1'b1, 1'b0);
        wait_flag(1'b1, 3000);
        wait_n(1'b0, 2, 400);
        clear();
        wait_n(1'b0, 2, 400);
        if (rx_t.size() >= 2) chk_rng(rx_t[1] - rx_t[0], 137, 138);
        set_cfg(3'h0, 1'b0, 1'b1, 1'b1);
        chk(receive_info_reg_three, 8'h00);
        set_cfg(3'h0, 1'b0, 1'b0, 1'b0);
        send(1'b0, 8'h01, 6'h3e, 32'h0000_0000);
        wait_flag(1'b1, 400);
        $display("overflow protection test done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge i_mclk);
        num_errors++;
        $display("BAD %0t run too long", $time);
        finish_test();
    end
    initial
    begin
        i_rst_b = 1'b0; line_interface_control = '0; go = 1'b0; sel = 1'b0; period = 8'h01; count = 6'h00; pattern = 32'h0;
        repeat (10) @(posedge i_mclk);
        chk(8'(lbo), 8'h00);
        chk(receive_info_reg_three, 8'h00);
        chk(8'(clk_lvl), 8'h01);
        i_rst_b <= 1'b1;
        t_lbo();
        t_bypass();
        t_side();
        t_gapped();
        t_trip();
        finish_test();
    end
endmodule // t1ja_top_tb
